// ### src/modulus_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module modulus_sequencer
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic presc_edge_i,
  input wire logic [11:0] cnt_one_i,
  input wire logic [7:0] cnt_two_i,
  input wire logic [3:0] cnt_three_i,
  input wire logic [3:0] cnt_four_i,
  input wire logic [2:0] inc_i,
  input wire logic [3:0] modulus_i,
  output logic [1:0] ctl_o,
  output logic [2:0] acc_o,
  output logic cycle_o
);
  typedef enum logic [1:0] {PH_TWO, PH_THREE, PH_FOUR, PH_ONE} phase_t;
  phase_t phase;
  logic [11:0] cnt [4];
  logic [3:0] sum;
  logic ovf;
  logic last;

  assign sum = {1'b0, acc_o} + {1'b0, inc_i};
  assign ovf = sum >= modulus_i;
  assign last = (phase == PH_ONE) && (cnt[3] <= 12'h001);

  function automatic logic [1:0] ctl_of(input phase_t p);
    case (p)
      PH_TWO: ctl_of = synth_loader_pkg::PRESC_RATIO_TWO;
      PH_THREE: ctl_of = synth_loader_pkg::PRESC_RATIO_THREE;
      PH_FOUR: ctl_of = synth_loader_pkg::PRESC_RATIO_FOUR;
      default: ctl_of = synth_loader_pkg::PRESC_RATIO_ONE;
    endcase
  endfunction

  // Ratio two, three, four, then one; a zero count still lasts one prescaler edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase <= PH_ONE;
      cnt <= '{default: 12'h000};
      acc_o <= 3'h0;
      ctl_o <= synth_loader_pkg::PRESC_RATIO_ONE;
      cycle_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cycle_o <= 1'b0;
      if (run_i && presc_edge_i)
      begin
        if (last)
        begin
          // Overflow borrows one ratio-one cycle as ratio two: N+1
          acc_o <= ovf ? 3'(sum - modulus_i) : sum[2:0];
          cnt[0] <= 12'({4'h0, cnt_two_i} + {11'h0, ovf});
          cnt[1] <= {8'h00, cnt_three_i};
          cnt[2] <= {8'h00, cnt_four_i};
          cnt[3] <= cnt_one_i - {11'h0, ovf};
          cycle_o <= 1'b1;
          phase <= PH_TWO;
          ctl_o <= ctl_of(PH_TWO);
        end
        else if (cnt[phase] <= 12'h001)
        begin
          cnt[phase] <= 12'h000;
          phase <= phase_t'(phase + 2'h1);
          ctl_o <= ctl_of(phase_t'(phase + 2'h1));
        end
        else
        begin
          cnt[phase] <= cnt[phase] - 12'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### src/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
  parameter int W = 4
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;

  // Two stages, then one more for edge finding
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= '0;
      level_o <= '0;
      prev <= '0;
    end
    else if (ce_i)
    begin
      meta <= pin_i;
      level_o <= meta;
      prev <= level_o;
    end
  end

  assign rise_o = level_o & ~prev;
endmodule
`default_nettype wire

// ### src/synth_loader_pkg.sv
package synth_loader_pkg;
  // ****************************************************
  // Link timing
  // ****************************************************
  localparam int SYS_CLK_MHZ = 100;
  localparam int LINK_MAX_MBPS = 10;
  localparam int LINK_BIT_NS = 1000 / LINK_MAX_MBPS;
  localparam int LINK_HALF_CYC = (LINK_BIT_NS / 2) * SYS_CLK_MHZ / 1000;
  // ****************************************************
  // Shift register and word identifiers
  // ****************************************************
  localparam int SR_W = 32;
  localparam int ID_LSB = 28;
  localparam logic [3:0] ID_MULTI = 4'h8;
  localparam logic [3:0] ID_AUX = 4'h9;
  localparam logic [3:0] ID_REF = 4'hA;
  // ****************************************************
  // Field positions in the shift register
  // ****************************************************
  localparam int FRAC_INC_LSB = 28;
  localparam int RATIO_ONE_LSB = 16;
  localparam int RATIO_TWO_LSB = 8;
  localparam int SCALE_LONG_LSB = 0;
  localparam int B_SUM_LSB = 24;
  localparam int B_SCALE_LSB = 16;
  localparam int B_K_LSB = 12;
  localparam int B_L_LSB = 10;
  localparam int B_P_LSB = 8;
  localparam int AUX_DIV_LSB = 16;
  localparam int REF_DIV_LSB = 16;
  localparam int MAIN_SEL_LSB = 14;
  localparam int MAIN_OFF_BIT = 13;
  localparam int AUX_SEL_LSB = 11;
  localparam int AUX_OFF_BIT = 10;
  localparam int MODULUS_SEL_BIT = 9;
  localparam int LONG_BIT = 8;
  // ****************************************************
  // Encodings and reset values
  // ****************************************************
  localparam logic [1:0] CODE_TWO = 2'h0;
  localparam logic [1:0] CODE_THREE = 2'h1;
  localparam logic [1:0] CODE_FOUR = 2'h2;
  localparam logic [1:0] PRESC_RATIO_ONE = 2'h1;
  localparam logic [1:0] PRESC_RATIO_TWO = 2'h0;
  localparam logic [1:0] PRESC_RATIO_THREE = 2'h2;
  localparam logic [1:0] PRESC_RATIO_FOUR = 2'h3;
  localparam logic [3:0] FRAC_MOD_FIVE = 4'h5;
  localparam logic [3:0] FRAC_MOD_EIGHT = 4'h8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// ### src/synth_serial_program_loader.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Three-wire data, clock and strobe link at up to 10 Mbit/s.
// - Strobe copies words to working registers; setup word waits for main word.
// - Transfer happens on the strobe rising edge.
// - Main word strobe enters speed-up while strobe stays high.
// - Serial clock pulses ignored while strobe is high.
// - Bits taken on leading clock edge, word LSB first.
// - Each field is sent from its own MSB first.
// - Short main word: zero id, 3-bit increment, 12-bit and 8-bit counts.
// - 8-bit field is ratio-two count, or 4-bit count plus 4-bit sum.
// - Format bit picks short or long main word with 8-bit scale factor.
// - Setup word: id 1000, sum, scale, integral, proportional, ratio code.
// - Ratio code 00 two, 01 three, 10 four ratios; sequencer still spends one prescaler edge in each zero-count ratio.
// - Aux word: id 1001, 12-bit aux divide, eight free bits.
// - Reference word: id 1010, divide, selects, disables, modulus, format.
// - Main reference select codes give M, 2M, 4M, 8M.
// - Aux reference select codes give M, 2M, 4M, 8M.
// - Modulus bit gives accumulator modulus 5 or 8.
// - Aux synthesiser disabled when its disable bit is one.
// - Main synthesiser disabled when its disable bit is one.
// - Prescaler control 01 ratio one, 00 two, 10 three, 11 four.
// - Accumulator adds increment each comparison cycle; overflow gives N+1.
module synth_serial_program_loader
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic SDATA_I,
  input wire logic SCLK_I,
  input wire logic STROBE_I,
  input wire logic PRESC_PULSE_I,
  output logic SPEEDUP_O,
  output logic MAIN_DISABLE_O,
  output logic AUX_DISABLE_O,
  output logic [2:0] FRAC_INCREMENT_O,
  output logic [11:0] RATIO_ONE_COUNT_O,
  output logic [7:0] RATIO_TWO_FIELD_O,
  output logic [3:0] RATIO_TWO_COUNT_O,
  output logic [3:0] RATIO_THREE_COUNT_O,
  output logic [3:0] RATIO_FOUR_COUNT_O,
  output logic [7:0] CURRENT_SCALE_FACTOR_O,
  output logic [3:0] INTEGRAL_ACCEL_O,
  output logic [1:0] PROP_ACCEL_O,
  output logic [1:0] RATIO_COUNT_CODE_O,
  output logic [11:0] AUX_DIVIDE_VALUE_O,
  output logic [11:0] REF_DIVIDE_VALUE_O,
  output logic [3:0] MAIN_REF_FACTOR_O,
  output logic [3:0] AUX_REF_FACTOR_O,
  output logic [3:0] FRAC_MODULUS_O,
  output logic LONG_FORMAT_O,
  output logic PRESCALER_CTL_HI_O,
  output logic PRESCALER_CTL_LO_O,
  output logic [2:0] FRAC_ACC_O,
  output logic CMP_CYCLE_O
);
  // ****************************************************
  // Declarations
  // ****************************************************
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic sdata;
  logic sclk_rise;
  logic stb_level;
  logic stb_rise;
  logic presc_rise;
  logic [31:0] shift_reg;
  logic is_main;
  logic [3:0] word_id;
  // Working registers
  logic [2:0] frac_increment;
  logic [11:0] ratio_one_count;
  logic [7:0] ratio_two_field;
  logic [7:0] current_scale_factor;
  logic [3:0] sum_two_to_four;
  logic [3:0] integral_accel;
  logic [1:0] prop_accel;
  logic [1:0] ratio_count_code;
  logic [11:0] aux_divide_value;
  logic [11:0] ref_divide_value;
  logic [1:0] main_ref_sel;
  logic [1:0] aux_ref_sel;
  logic main_disable;
  logic aux_disable;
  logic frac_modulus_sel;
  logic long_format;
  logic speedup;
  // Temporary holding for the setup word
  logic setup_pending;
  logic [3:0] tmp_sum;
  logic [7:0] tmp_scale;
  logic [3:0] tmp_integral;
  logic [1:0] tmp_prop;
  logic [1:0] tmp_code;
  // Derived counts
  logic [3:0] ratio_two_count;
  logic [3:0] ratio_three_count;
  logic [3:0] ratio_four_count;
  logic [3:0] next_two;
  logic [3:0] next_three;
  logic [3:0] next_four;
  logic [3:0] main_ref_factor;
  logic [3:0] aux_ref_factor;
  logic [3:0] frac_modulus;
  logic [1:0] presc_ctl;

  // ****************************************************
  // Functions
  // ****************************************************
  // Field sent MSB first inside an LSB-first word: reverse it
  function automatic logic [11:0] get_field(input logic [31:0] sr, input int lsb,
                                            input int w);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 0; i < 12; i++)
    begin
      if (i < w)
      begin
        r[i] = sr[lsb + w - 1 - i];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] ref_factor(input logic [1:0] sel);
    ref_factor = 4'h1 << sel;
  endfunction

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  pin_sync #(
    .W(3)
  ) u_link_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .pin_i({STROBE_I, SCLK_I, SDATA_I}),
    .level_o(pin_level),
    .rise_o(pin_rise)
  );

  pin_sync #(
    .W(1)
  ) u_presc_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .pin_i(PRESC_PULSE_I),
    .level_o(),
    .rise_o(presc_rise)
  );

  assign sdata = pin_level[0];
  assign sclk_rise = pin_rise[1];
  assign stb_level = pin_level[2];
  assign stb_rise = pin_rise[2];

  // ****************************************************
  // Shift register
  // ****************************************************
  // Data taken on the leading clock edge, word MSB lands at bit 31
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      shift_reg <= synth_loader_pkg::RST_WORD;
    end
    else if (CE_I && sclk_rise && !stb_level)
    begin
      shift_reg <= {sdata, shift_reg[31:1]};
    end
  end

  assign word_id = shift_reg[31:synth_loader_pkg::ID_LSB];
  assign is_main = !shift_reg[31];

  // ****************************************************
  // Main divide word
  // ****************************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      frac_increment <= 3'h0;
      ratio_one_count <= 12'h000;
      ratio_two_field <= 8'h00;
    end
    else if (CE_I && stb_rise && is_main)
    begin
      frac_increment <= 3'(get_field(shift_reg, synth_loader_pkg::FRAC_INC_LSB, 3));
      ratio_one_count <= get_field(shift_reg, synth_loader_pkg::RATIO_ONE_LSB, 12);
      ratio_two_field <= 8'(get_field(shift_reg, synth_loader_pkg::RATIO_TWO_LSB, 8));
    end
  end

  // ****************************************************
  // Multimodulus setup word and its commit
  // ****************************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      setup_pending <= 1'b0;
      tmp_sum <= 4'h0;
      tmp_scale <= 8'h00;
      tmp_integral <= 4'h0;
      tmp_prop <= 2'h0;
      tmp_code <= 2'h0;
    end
    else if (CE_I && stb_rise)
    begin
      if (!is_main && word_id == synth_loader_pkg::ID_MULTI)
      begin
        setup_pending <= 1'b1;
        tmp_sum <= 4'(get_field(shift_reg, synth_loader_pkg::B_SUM_LSB, 4));
        tmp_scale <= 8'(get_field(shift_reg, synth_loader_pkg::B_SCALE_LSB, 8));
        tmp_integral <= 4'(get_field(shift_reg, synth_loader_pkg::B_K_LSB, 4));
        tmp_prop <= 2'(get_field(shift_reg, synth_loader_pkg::B_L_LSB, 2));
        tmp_code <= 2'(get_field(shift_reg, synth_loader_pkg::B_P_LSB, 2));
      end
      else if (is_main)
      begin
        setup_pending <= 1'b0;
      end
    end
  end

  // Working copy of setup fields; long word overrides the scale factor
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      current_scale_factor <= 8'h00;
      sum_two_to_four <= 4'h0;
      integral_accel <= 4'h0;
      prop_accel <= 2'h0;
      ratio_count_code <= synth_loader_pkg::CODE_TWO;
    end
    else if (CE_I && stb_rise && is_main)
    begin
      if (setup_pending)
      begin
        sum_two_to_four <= tmp_sum;
        current_scale_factor <= tmp_scale;
        integral_accel <= tmp_integral;
        prop_accel <= tmp_prop;
        ratio_count_code <= tmp_code;
      end
      if (long_format)
      begin
        current_scale_factor <= 8'(get_field(shift_reg, synth_loader_pkg::SCALE_LONG_LSB, 8));
      end
    end
  end

  // ****************************************************
  // Auxiliary divide and reference config words
  // ****************************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      aux_divide_value <= 12'h000;
    end
    else if (CE_I && stb_rise && !is_main && word_id == synth_loader_pkg::ID_AUX)
    begin
      aux_divide_value <= get_field(shift_reg, synth_loader_pkg::AUX_DIV_LSB, 12);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ref_divide_value <= 12'h000;
      main_ref_sel <= 2'h0;
      main_disable <= 1'b0;
      aux_ref_sel <= 2'h0;
      aux_disable <= 1'b0;
      frac_modulus_sel <= 1'b0;
      long_format <= 1'b0;
    end
    else if (CE_I && stb_rise && !is_main && word_id == synth_loader_pkg::ID_REF)
    begin
      ref_divide_value <= get_field(shift_reg, synth_loader_pkg::REF_DIV_LSB, 12);
      main_ref_sel <= 2'(get_field(shift_reg, synth_loader_pkg::MAIN_SEL_LSB, 2));
      main_disable <= shift_reg[synth_loader_pkg::MAIN_OFF_BIT];
      aux_ref_sel <= 2'(get_field(shift_reg, synth_loader_pkg::AUX_SEL_LSB, 2));
      aux_disable <= shift_reg[synth_loader_pkg::AUX_OFF_BIT];
      frac_modulus_sel <= shift_reg[synth_loader_pkg::MODULUS_SEL_BIT];
      long_format <= shift_reg[synth_loader_pkg::LONG_BIT];
    end
  end

  // ****************************************************
  // Speed-up mode
  // ****************************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      speedup <= 1'b0;
    end
    else if (CE_I)
    begin
      if (stb_rise && is_main)
      begin
        speedup <= 1'b1;
      end
      else if (!stb_level)
      begin
        speedup <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Ratio counts and decodes
  // ****************************************************
  always_comb
  begin
    next_two = 4'h0;
    next_three = 4'h0;
    next_four = 4'h0;
    case (ratio_count_code)
      synth_loader_pkg::CODE_THREE:
      begin
        next_two = ratio_two_field[7:4];
        next_three = ratio_two_field[3:0] - ratio_two_field[7:4];
      end
      synth_loader_pkg::CODE_FOUR:
      begin
        next_two = ratio_two_field[7:4];
        next_three = ratio_two_field[3:0] - ratio_two_field[7:4];
        next_four = sum_two_to_four - ratio_two_field[3:0];
      end
      default:
      begin
        next_two = 4'h0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ratio_two_count <= 4'h0;
      ratio_three_count <= 4'h0;
      ratio_four_count <= 4'h0;
      main_ref_factor <= 4'h1;
      aux_ref_factor <= 4'h1;
      frac_modulus <= synth_loader_pkg::FRAC_MOD_FIVE;
    end
    else if (CE_I)
    begin
      ratio_two_count <= next_two;
      ratio_three_count <= next_three;
      ratio_four_count <= next_four;
      main_ref_factor <= ref_factor(main_ref_sel);
      aux_ref_factor <= ref_factor(aux_ref_sel);
      frac_modulus <= frac_modulus_sel ? synth_loader_pkg::FRAC_MOD_EIGHT
                                       : synth_loader_pkg::FRAC_MOD_FIVE;
    end
  end

  // ****************************************************
  // Prescaler modulus sequencing
  // ****************************************************
  modulus_sequencer u_seq (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .run_i(!main_disable),
    .presc_edge_i(presc_rise),
    .cnt_one_i(ratio_one_count),
    .cnt_two_i(ratio_count_code == synth_loader_pkg::CODE_TWO ? ratio_two_field
                                                               : {4'h0, ratio_two_count}),
    .cnt_three_i(ratio_three_count),
    .cnt_four_i(ratio_four_count),
    .inc_i(frac_increment),
    .modulus_i(frac_modulus),
    .ctl_o(presc_ctl),
    .acc_o(FRAC_ACC_O),
    .cycle_o(CMP_CYCLE_O)
  );

  // ****************************************************
  // Outputs
  // ****************************************************
  assign SPEEDUP_O = speedup;
  assign MAIN_DISABLE_O = main_disable;
  assign AUX_DISABLE_O = aux_disable;
  assign FRAC_INCREMENT_O = frac_increment;
  assign RATIO_ONE_COUNT_O = ratio_one_count;
  assign RATIO_TWO_FIELD_O = ratio_two_field;
  assign RATIO_TWO_COUNT_O = ratio_two_count;
  assign RATIO_THREE_COUNT_O = ratio_three_count;
  assign RATIO_FOUR_COUNT_O = ratio_four_count;
  assign CURRENT_SCALE_FACTOR_O = current_scale_factor;
  assign INTEGRAL_ACCEL_O = integral_accel;
  assign PROP_ACCEL_O = prop_accel;
  assign RATIO_COUNT_CODE_O = ratio_count_code;
  assign AUX_DIVIDE_VALUE_O = aux_divide_value;
  assign REF_DIVIDE_VALUE_O = ref_divide_value;
  assign MAIN_REF_FACTOR_O = main_ref_factor;
  assign AUX_REF_FACTOR_O = aux_ref_factor;
  assign FRAC_MODULUS_O = frac_modulus;
  assign LONG_FORMAT_O = long_format;
  assign PRESCALER_CTL_HI_O = presc_ctl[1];
  assign PRESCALER_CTL_LO_O = presc_ctl[0];
endmodule
`default_nettype wire

// ### tb/loader_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module loader_host
(
  output logic sdata_o,
  output logic sclk_o,
  output logic strobe_o
);
  initial
  begin
    sdata_o = 1'b0;
    sclk_o = 1'b0;
    strobe_o = 1'b0;
  end
  // Link clock of 125 ns runs only inside frames
  task automatic bits(input logic [31:0] f, input int n, input logic st);
    int i;
    for (i = 32 - n; i < 32; i++)
    begin
      sdata_o <= f[i];
      #31.3 sclk_o <= 1'b1;
      #62.5 sclk_o <= 1'b0;
      if (st && i == 31)
        strobe_o <= 1'b1;
      #31.2;
    end
  endtask
  task automatic send(input logic [31:0] f, input int n, input logic [31:0] j, input int nj);
    if (n == 0)
      strobe_o <= 1'b1;
    bits(f, n, 1'b1);
    bits(j, nj, 1'b0);
    sdata_o <= ~sdata_o;
  endtask
  task automatic drop;
    #1000 strobe_o <= 1'b0;
    #500;
  endtask
endmodule
`default_nettype wire

// ### tb/synth_loader_checker.sv
`timescale 1ns/100ps
`default_nettype none
module synth_loader_checker
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic STROBE_I,
  input wire logic SPEEDUP_O,
  input wire logic MAIN_DISABLE_O,
  input wire logic [11:0] RATIO_ONE_COUNT_O,
  input wire logic [11:0] AUX_DIVIDE_VALUE_O,
  input wire logic [11:0] REF_DIVIDE_VALUE_O,
  input wire logic [3:0] RATIO_THREE_COUNT_O,
  input wire logic [3:0] RATIO_FOUR_COUNT_O,
  input wire logic [1:0] RATIO_COUNT_CODE_O,
  input wire logic [3:0] MAIN_REF_FACTOR_O,
  input wire logic [3:0] AUX_REF_FACTOR_O,
  input wire logic [3:0] FRAC_MODULUS_O,
  input wire logic [2:0] FRAC_ACC_O,
  input wire logic CMP_CYCLE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_main_ref_pow: assert property ($onehot(MAIN_REF_FACTOR_O))
    else $error("main reference factor illegal");
  a_aux_ref_pow: assert property ($onehot(AUX_REF_FACTOR_O))
    else $error("aux reference factor illegal");
  a_frac_mod_legal: assert property (FRAC_MODULUS_O == 4'h5 || FRAC_MODULUS_O == 4'h8)
    else $error("accumulator modulus illegal");
  a_acc_in_range: assert property (CMP_CYCLE_O |=> ##1 ({1'b0, FRAC_ACC_O} < FRAC_MODULUS_O))
    else $error("accumulator beyond modulus");
  a_speedup_cause: assert property ($rose(SPEEDUP_O) |-> $past(STROBE_I, 2))
    else $error("speed-up without strobe");
  a_speedup_end: assert property ((!STROBE_I) [*6] |-> !SPEEDUP_O)
    else $error("speed-up outlives strobe");
  a_cfg_hold: assert property ((!STROBE_I) [*8] |-> $stable(RATIO_ONE_COUNT_O) &&
    $stable(AUX_DIVIDE_VALUE_O) && $stable(REF_DIVIDE_VALUE_O))
    else $error("working register changed without strobe");
  a_two_mode_zero: assert property (RATIO_COUNT_CODE_O == 2'h0 &&
    $past(RATIO_COUNT_CODE_O) == 2'h0 |-> RATIO_THREE_COUNT_O == 4'h0 && RATIO_FOUR_COUNT_O == 4'h0)
    else $error("extra counts in two-ratio mode");
  a_main_off_idle: assert property (MAIN_DISABLE_O && $past(MAIN_DISABLE_O, 2) |-> !CMP_CYCLE_O)
    else $error("comparison cycle while main disabled");
endmodule
`default_nettype wire

// ### tb/synth_serial_program_loader_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module synth_serial_program_loader_tb_top;
  logic clk;
  logic rst_n;
  logic sdata;
  logic sclk;
  logic strobe;
  logic [2:0] pc;
  int checks;
  int n_fail;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial pc = 3'h0;
  // Prescaler stand-in, one rising edge every eight clocks
  always @(posedge clk) pc <= pc + 3'h1;
  loader_host i_host (.sdata_o(sdata), .sclk_o(sclk), .strobe_o(strobe));
  synth_serial_program_loader i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .SDATA_I(sdata), .SCLK_I(sclk), .STROBE_I(strobe), .PRESC_PULSE_I(pc[2]), .SPEEDUP_O(),
    .MAIN_DISABLE_O(), .AUX_DISABLE_O(), .FRAC_INCREMENT_O(), .RATIO_ONE_COUNT_O(),
    .RATIO_TWO_FIELD_O(), .RATIO_TWO_COUNT_O(), .RATIO_THREE_COUNT_O(), .RATIO_FOUR_COUNT_O(),
    .CURRENT_SCALE_FACTOR_O(), .INTEGRAL_ACCEL_O(), .PROP_ACCEL_O(), .RATIO_COUNT_CODE_O(),
    .AUX_DIVIDE_VALUE_O(), .REF_DIVIDE_VALUE_O(), .MAIN_REF_FACTOR_O(), .AUX_REF_FACTOR_O(),
    .FRAC_MODULUS_O(), .LONG_FORMAT_O(), .PRESCALER_CTL_HI_O(), .PRESCALER_CTL_LO_O(),
    .FRAC_ACC_O(), .CMP_CYCLE_O());
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Each field goes in with its own top bit toward the word's low end
  function automatic logic [31:0] fld(input logic [31:0] f, input int lsb, input int w,
    input logic [11:0] v);
    int i;
    for (i = 0; i < w; i++)
      f[lsb + i] = v[w - 1 - i];
    return f;
  endfunction
  task automatic wait_cmp(inout logic [3:0] seen);
    int t;
    for (t = 0; t < 1000 && i_dut.CMP_CYCLE_O !== 1'b1; t++)
    begin
      wt(1);
      seen[{i_dut.PRESCALER_CTL_HI_O, i_dut.PRESCALER_CTL_LO_O}] = 1'b1;
    end
    if (t == 1000)
    begin
      n_fail++;
      summarize;
    end
    wt(2);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_ref;
    logic [31:0] f;
    int k;
    for (k = 0; k < 4; k++)
    begin
      f = fld(fld(fld({4'hA, 28'h0}, 16, 12, 12'h100 + k), 14, 2, k), 11, 2, 3 - k);
      f[13] = (k == 1);
      f[10] = k[0];
      f[9] = k[1];
      i_host.send(f, 24, 32'h0, 0);
      i_host.drop;
      chk("ref_div", i_dut.REF_DIVIDE_VALUE_O, 12'h100 + k);
      chk("main_ref", i_dut.MAIN_REF_FACTOR_O, 32'h1 << k);
      chk("aux_ref", i_dut.AUX_REF_FACTOR_O, 32'h1 << (3 - k));
      chk("frac_mod", i_dut.FRAC_MODULUS_O, k[1] ? 4'h8 : 4'h5);
      chk("aux_off", i_dut.AUX_DISABLE_O, k[0]);
      chk("main_off", i_dut.MAIN_DISABLE_O, k == 1);
    end
  endtask
  task automatic t_main;
    logic [31:0] f;
    f = fld(fld(fld(32'h0, 28, 3, 3'h3), 16, 12, 12'h033), 8, 8, 8'h19);
    i_host.send(f, 24, 32'h0, 0);
    wt(20);
    chk("speedup", i_dut.SPEEDUP_O, 1'b1);
    i_host.drop;
    chk("speedup", i_dut.SPEEDUP_O, 1'b0);
    chk("frac_inc", i_dut.FRAC_INCREMENT_O, 3'h3);
    chk("ratio_one", i_dut.RATIO_ONE_COUNT_O, 12'h033);
    chk("ratio_two_field", i_dut.RATIO_TWO_FIELD_O, 8'h19);
  endtask
  task automatic t_ignore;
    logic [31:0] a;
    logic [31:0] b;
    a = fld({4'h9, 28'h0}, 16, 12, 12'h123);
    b = fld({4'h9, 28'h0}, 16, 12, 12'hABC);
    i_host.send(a, 24, b, 24);
    i_host.drop;
    chk("aux_div", i_dut.AUX_DIVIDE_VALUE_O, 12'h123);
    i_host.send(b, 0, 32'h0, 0);
    i_host.drop;
    chk("aux_div", i_dut.AUX_DIVIDE_VALUE_O, 12'h123);
  endtask
  task automatic t_modes;
    logic [31:0] s;
    logic [31:0] m;
    int c;
    for (c = 0; c < 3; c++)
    begin
      s = fld(fld(fld({4'h8, 28'h0}, 24, 4, 4'h9), 16, 8, 8'h40 + c), 12, 4, 4'h5 + c);
      s = fld(fld(s, 10, 2, c), 8, 2, c);
      m = fld(fld(fld(32'h0, 28, 3, c), 16, 12, 12'h010 + c), 8, 8, 8'h37);
      i_host.send(s, 24, 32'h0, 0);
      i_host.drop;
      chk("k_pend", i_dut.INTEGRAL_ACCEL_O, c == 0 ? 4'h0 : 4'h4 + c);
      i_host.send(m, 24, 32'h0, 0);
      i_host.drop;
      chk("code", i_dut.RATIO_COUNT_CODE_O, c);
      chk("k", i_dut.INTEGRAL_ACCEL_O, 4'h5 + c);
      chk("l", i_dut.PROP_ACCEL_O, c);
      chk("scale", i_dut.CURRENT_SCALE_FACTOR_O, 8'h40 + c);
      chk("ratio_two", i_dut.RATIO_TWO_COUNT_O, c == 0 ? 4'h0 : 4'h3);
      chk("ratio_three", i_dut.RATIO_THREE_COUNT_O, c == 0 ? 4'h0 : 4'h4);
      if (c == 2)
        chk("ratio_four", i_dut.RATIO_FOUR_COUNT_O, 4'h2);
    end
  endtask
  task automatic t_long;
    logic [31:0] f;
    f = fld(fld({4'hA, 28'h0}, 16, 12, 12'h103), 14, 2, 2'h3);
    f[10:8] = 3'h7;
    i_host.send(f, 24, 32'h0, 0);
    i_host.drop;
    f = fld(fld(fld(fld(32'h0, 28, 3, 3'h3), 16, 12, 12'h005), 8, 8, 8'h37), 0, 8, 8'hA5);
    i_host.send(f, 32, 32'h0, 0);
    i_host.drop;
    chk("long", i_dut.LONG_FORMAT_O, 1'b1);
    chk("scale", i_dut.CURRENT_SCALE_FACTOR_O, 8'hA5);
    chk("ratio_one", i_dut.RATIO_ONE_COUNT_O, 12'h005);
  endtask
  task automatic t_frac;
    logic [3:0] seen;
    logic [2:0] a0;
    seen = 4'h0;
    wait_cmp(seen);
    a0 = i_dut.FRAC_ACC_O;
    wait_cmp(seen);
    chk("acc", i_dut.FRAC_ACC_O, (a0 + 3'h3) % 4'h8);
    chk("ctl", seen, 4'hF);
  endtask
  initial
  begin
    rst_n = 1'b0;
    wt(12);
    rst_n <= 1'b1;
    wt(5);
    t_ref;
    t_main;
    t_ignore;
    t_modes;
    t_long;
    t_frac;
    summarize;
  end
endmodule
bind synth_serial_program_loader synth_loader_checker i_chk (.SYS_CLK_I, .RST_N_I, .STROBE_I,
  .SPEEDUP_O, .MAIN_DISABLE_O, .RATIO_ONE_COUNT_O, .AUX_DIVIDE_VALUE_O, .REF_DIVIDE_VALUE_O,
  .RATIO_THREE_COUNT_O, .RATIO_FOUR_COUNT_O, .RATIO_COUNT_CODE_O, .MAIN_REF_FACTOR_O,
  .AUX_REF_FACTOR_O, .FRAC_MODULUS_O, .FRAC_ACC_O, .CMP_CYCLE_O);
`default_nettype wire
